// file: load_shed_map.vh
// Constants for the load shedding configuration and review logic
`ifndef LOAD_SHED_MAP_VH
`define LOAD_SHED_MAP_VH

// Configuration switch positions (bit index, position minus one)
`define SW_ORDER_ONE_BIT    0
`define SW_ORDER_TWO_BIT    1
`define SW_ORDER_THREE_BIT  2
`define SW_GEN_MGMT_BIT     3
`define SW_GEN_RATING_BIT   4

// Factory setting: every position on
`define SW_FACTORY_VALUE    8'hff

// Generator current limits in amperes
`define GEN_LIMIT_LOW_AMPS  8'h2d
`define GEN_LIMIT_HIGH_AMPS 8'h3c

// Review inactivity time and clock rate
`define REVIEW_TIMEOUT_MS   5000
`define CLK_SYS_HZ          10000000
`define REVIEW_TIMEOUT_CYC  ((`REVIEW_TIMEOUT_MS / 1000) * `CLK_SYS_HZ)

// Number of relays and the first relay that switches low-voltage control
`define RELAY_COUNT         6
`define FIRST_LV_RELAY      5

`endif

// file: shed_order_rom.v
// Shed order lookup: order column and step to relay number
`timescale 1ns/1ps
`include "load_shed_map.vh"

module shed_order_rom (
	// Selection
	input  wire [2:0] column_idx,
	input  wire [2:0] step_idx,
	// Result
	output reg  [2:0] relay_num
);

	// Relay shed sequences, first shed at step zero
	always @* begin
		relay_num = 3'h0;
		case (column_idx)
			3'h0: begin // [R11]
				case (step_idx)
					3'h0: relay_num = 3'h6;
					3'h1: relay_num = 3'h5;
					3'h2: relay_num = 3'h4;
					3'h3: relay_num = 3'h3;
					3'h4: relay_num = 3'h2;
					default: relay_num = 3'h1;
				endcase
			end
			3'h1: begin // [R11]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h6;
					3'h2: relay_num = 3'h5;
					3'h3: relay_num = 3'h3;
					3'h4: relay_num = 3'h2;
					default: relay_num = 3'h1;
				endcase
			end
			3'h2: begin // [R11]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h3;
					3'h2: relay_num = 3'h6;
					3'h3: relay_num = 3'h5;
					3'h4: relay_num = 3'h2;
					default: relay_num = 3'h1;
				endcase
			end
			3'h3: begin // [R11]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h3;
					3'h2: relay_num = 3'h2;
					3'h3: relay_num = 3'h6;
					3'h4: relay_num = 3'h5;
					default: relay_num = 3'h1;
				endcase
			end
			3'h4: begin // [R12]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h3;
					3'h2: relay_num = 3'h2;
					3'h3: relay_num = 3'h1;
					3'h4: relay_num = 3'h6;
					default: relay_num = 3'h5;
				endcase
			end
			3'h5: begin // [R12]
				case (step_idx)
					3'h0: relay_num = 3'h6;
					3'h1: relay_num = 3'h4;
					3'h2: relay_num = 3'h5;
					3'h3: relay_num = 3'h3;
					3'h4: relay_num = 3'h2;
					default: relay_num = 3'h1;
				endcase
			end
			3'h6: begin // [R12]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h6;
					3'h2: relay_num = 3'h3;
					3'h3: relay_num = 3'h5;
					3'h4: relay_num = 3'h2;
					default: relay_num = 3'h1;
				endcase
			end
			default: begin // [R12]
				case (step_idx)
					3'h0: relay_num = 3'h4;
					3'h1: relay_num = 3'h3;
					3'h2: relay_num = 3'h6;
					3'h3: relay_num = 3'h2;
					3'h4: relay_num = 3'h5;
					default: relay_num = 3'h1;
				endcase
			end
		endcase
	end

endmodule

// file: load_shed_config_display.v
// Configuration decode and stored-value review for the load shedding controller
`timescale 1ns/1ps
`include "load_shed_map.vh"

// Overview of operation
// R1: Holding service-select enters review, lights top load indicator, shows its stored value.
// R2: Each further press in review advances to the next load and its indicator.
// R3: Review ends after the last load or five seconds without a press.
// R4: Switch positions 1-3 order, 4 generator management, 5 rating, 6-8 reserved.
// R5: All eight switch positions are treated as on when delivered.
// R6: Management switch on under generator: management off, meter still shows total current.
// R7: Management switch off under generator: management on with rating-chosen limit.
// R8: Rating switch on limits generator current to 45 amperes.
// R9: Rating switch off limits generator current to 60 amperes.
// R10: Three order switches decode to one of eight order columns.
// R11: Columns 1 to 4 use their fixed relay shed sequences.
// R12: Columns 5 to 8 use their fixed relay shed sequences.
// R13: Installer wires at most four line loads and two low-voltage loads in order.
// R14: Relays 1-4 switch line loads, relays 5-6 low-voltage control circuits.
// R15: Each load's stored value is the current drop when last shed.
// R16: Every press restarts the review timer; reserved switch positions are ignored.
module load_shed_config_display #(
	parameter REVIEW_TIMEOUT_CYCLES = `REVIEW_TIMEOUT_CYC,
	parameter CUR_W                 = 8
) (
	// Clock and reset
	input  wire                 clk_sys,
	input  wire                 rst_n,
	// Installer configuration switch, bit 0 is position 1, high means on
	input  wire [7:0]           config_switch,
	// Operator button, high while pressed
	input  wire                 service_select_button,
	// Generator running sense
	input  wire                 generator_present,
	// Measurement side
	input  wire [CUR_W-1:0]     total_current,
	input  wire                 shed_event,
	input  wire [2:0]           shed_relay,
	input  wire [CUR_W-1:0]     shed_current_drop,
	// Order lookup for the shedding logic
	input  wire [2:0]           shed_step,
	output reg  [2:0]           shed_step_relay,
	// Generator energy management
	output reg                  energy_mgmt_enable,
	output reg  [CUR_W-1:0]     current_limit_amps,
	output reg  [5:0]           relay_is_low_voltage,
	// Display panel
	output reg  [CUR_W-1:0]     load_meter_value,
	output reg  [5:0]           load_indicator,
	output reg                  review_active
);

	localparam ST_NORMAL = 1'b0;
	localparam ST_REVIEW = 1'b1;
	localparam [31:0] TIMEOUT_LAST = REVIEW_TIMEOUT_CYCLES - 1;

	// Synchronisers for the asynchronous pins
	reg  [7:0]       sw_meta_ff;
	reg  [7:0]       sw_sync_ff;
	reg              btn_meta_ff;
	reg              btn_sync_ff;
	reg              btn_prev_ff;
	reg              gen_meta_ff;
	reg              gen_sync_ff;

	// Review state
	reg              state_ff;
	reg              nxt_state;
	reg  [2:0]       review_idx_ff;
	reg  [2:0]       nxt_review_idx;
	reg  [31:0]      idle_cnt_ff;
	reg  [31:0]      nxt_idle_cnt;

	// Stored value per load
	reg  [CUR_W-1:0] stored_ff [0:5];

	wire             press;
	wire [2:0]       order_column;
	wire [2:0]       rom_relay;
	wire             gen_mgmt_sw;
	wire             gen_rating_sw;

	// Two-flop sampling, switches start at the factory setting
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sw_meta_ff  <= `SW_FACTORY_VALUE; // [R5]
			sw_sync_ff  <= `SW_FACTORY_VALUE; // [R5]
			btn_meta_ff <= 1'b0;
			btn_sync_ff <= 1'b0;
			btn_prev_ff <= 1'b0;
			gen_meta_ff <= 1'b0;
			gen_sync_ff <= 1'b0;
		end else begin
			sw_meta_ff  <= config_switch;
			sw_sync_ff  <= sw_meta_ff;
			btn_meta_ff <= service_select_button;
			btn_sync_ff <= btn_meta_ff;
			btn_prev_ff <= btn_sync_ff;
			gen_meta_ff <= generator_present;
			gen_sync_ff <= gen_meta_ff;
		end
	end

	// Press edge; positions 6 to 8 are never read
	assign press         = btn_sync_ff & ~btn_prev_ff; // [R16]
	assign gen_mgmt_sw   = sw_sync_ff[`SW_GEN_MGMT_BIT]; // [R4]
	assign gen_rating_sw = sw_sync_ff[`SW_GEN_RATING_BIT]; // [R4]

	// Off switch sets the column bit: column index is zero-based
	assign order_column = {~sw_sync_ff[`SW_ORDER_THREE_BIT],
	                       ~sw_sync_ff[`SW_ORDER_TWO_BIT],
	                       ~sw_sync_ff[`SW_ORDER_ONE_BIT]}; // [R10]

	shed_order_rom u_order (
		.column_idx (order_column),
		.step_idx   (shed_step),
		.relay_num  (rom_relay)
	);

	// Stored current drop per load, captured on each shed
	genvar gi;
	generate
		for (gi = 0; gi < `RELAY_COUNT; gi = gi + 1) begin : g_store
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stored_ff[gi] <= {CUR_W{1'b0}};
				end else if (shed_event && shed_relay == gi + 1) begin
					stored_ff[gi] <= shed_current_drop; // [R15]
				end
			end
		end
	endgenerate

	// Review state machine
	always @* begin
		nxt_state      = state_ff;
		nxt_review_idx = review_idx_ff;
		nxt_idle_cnt   = idle_cnt_ff;
		case (state_ff)
			ST_NORMAL: begin
				if (press) begin
					nxt_state      = ST_REVIEW; // [R1]
					nxt_review_idx = 3'h0;
					nxt_idle_cnt   = 32'h0;
				end
			end
			ST_REVIEW: begin
				if (press) begin
					nxt_idle_cnt = 32'h0; // [R16]
					if (review_idx_ff == 3'h5) begin
						nxt_state = ST_NORMAL; // [R3]
					end else begin
						nxt_review_idx = review_idx_ff + 3'h1; // [R2]
					end
				end else if (idle_cnt_ff >= TIMEOUT_LAST) begin
					nxt_state = ST_NORMAL; // [R3]
				end else begin
					nxt_idle_cnt = idle_cnt_ff + 32'h1;
				end
			end
			default: begin
				nxt_state = ST_NORMAL;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff      <= ST_NORMAL;
			review_idx_ff <= 3'h0;
			idle_cnt_ff   <= 32'h0;
		end else begin
			state_ff      <= nxt_state;
			review_idx_ff <= nxt_review_idx;
			idle_cnt_ff   <= nxt_idle_cnt;
		end
	end

	// Registered outputs
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shed_step_relay      <= 3'h0;
			energy_mgmt_enable   <= 1'b0;
			current_limit_amps   <= `GEN_LIMIT_LOW_AMPS;
			relay_is_low_voltage <= 6'h30;
			load_meter_value     <= {CUR_W{1'b0}};
			load_indicator       <= 6'h00;
			review_active        <= 1'b0;
		end else begin
			shed_step_relay      <= rom_relay; // [R11] [R12]
			// Management only under generator with the switch off
			energy_mgmt_enable   <= gen_sync_ff & ~gen_mgmt_sw; // [R6] [R7]
			current_limit_amps   <= gen_rating_sw ? `GEN_LIMIT_LOW_AMPS // [R8]
			                                      : `GEN_LIMIT_HIGH_AMPS; // [R9]
			relay_is_low_voltage <= 6'h30; // [R14]
			review_active        <= (state_ff == ST_REVIEW);
			if (state_ff == ST_REVIEW) begin
				load_meter_value <= stored_ff[review_idx_ff]; // [R1] [R2]
				load_indicator   <= 6'h20 >> review_idx_ff; // [R1]
			end else begin
				load_meter_value <= total_current; // [R6] [R3]
				load_indicator   <= 6'h00;
			end
		end
	end

endmodule

// file: lsd_props.sv
// Assertion checker for the load shed configuration and review block
`timescale 1ns/1ps
module lsd_props #(
	parameter REVIEW_TIMEOUT_CYCLES = 20,
	parameter CUR_W = 8
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Inputs
	input wire [7:0] config_switch,
	input wire service_select_button,
	input wire generator_present,
	input wire [CUR_W-1:0] total_current,
	input wire shed_event,
	input wire [2:0] shed_relay,
	input wire [CUR_W-1:0] shed_current_drop,
	input wire [2:0] shed_step,
	// Outputs
	input wire [2:0] shed_step_relay,
	input wire energy_mgmt_enable,
	input wire [CUR_W-1:0] current_limit_amps,
	input wire [5:0] relay_is_low_voltage,
	input wire [CUR_W-1:0] load_meter_value,
	input wire [5:0] load_indicator,
	input wire review_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	reg [31:0] idle_ff;
	// Cycles since the button was last held, wide enough for the full five seconds
	always @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			idle_ff <= 32'h0;
		else if (service_select_button)
			idle_ff <= 32'h0;
		else if (idle_ff != 32'hffffffff)
			idle_ff <= idle_ff + 32'h1;
	a_rating_limit: assert property ($stable(config_switch) [*4] |->
		current_limit_amps == (config_switch[4] ? 8'h2d : 8'h3c)) else $error("limit wrong");
	a_mgmt_enable: assert property (($stable(config_switch) && $stable(generator_present)) [*4] |->
		energy_mgmt_enable == (generator_present && !config_switch[3])) else $error("mgmt wrong");
	a_low_voltage: assert property (relay_is_low_voltage == 6'h30) else $error("relay type wrong");
	a_meter_total: assert property (!review_active && $past(!review_active) && $past(rst_n) |->
		load_meter_value == $past(total_current)) else $error("meter not total");
	a_ind_onehot: assert property ($onehot0(load_indicator) && review_active == |load_indicator)
		else $error("indicator wrong");
	a_enter_top: assert property ($rose(review_active) |-> load_indicator == 6'h20) else $error("not top");
	a_advance_next: assert property (review_active && $past(review_active) && $changed(load_indicator) |->
		load_indicator == $past(load_indicator) >> 1) else $error("bad advance");
	a_early_exit: assert property ($fell(review_active) && $past(load_indicator) != 6'h01 |->
		idle_ff >= REVIEW_TIMEOUT_CYCLES - 4) else $error("early exit");
	a_idle_timeout: assert property (idle_ff > REVIEW_TIMEOUT_CYCLES + 6 |-> !review_active)
		else $error("no timeout");
	a_col_one: assert property (($stable(config_switch) && $stable(shed_step)) [*4] ##0
		(config_switch[2:0] == 3'h7 && shed_step == 3'h0) |-> shed_step_relay == 3'h6) else $error("order");
endmodule
bind load_shed_config_display lsd_props #(.REVIEW_TIMEOUT_CYCLES(REVIEW_TIMEOUT_CYCLES), .CUR_W(CUR_W)) u_props (
	.clk_sys, .rst_n, .config_switch, .service_select_button, .generator_present, .total_current, .shed_event,
	.shed_relay, .shed_current_drop, .shed_step, .shed_step_relay, .energy_mgmt_enable, .current_limit_amps,
	.relay_is_low_voltage, .load_meter_value, .load_indicator, .review_active);

// file: panel_model.sv
// Installer switch block and operator button model
`timescale 1ns/1ps
module panel_model (
	// Clock
	input wire clk_sys,
	// Panel side
	output reg [7:0] config_switch,
	output reg service_select_button
);
	// Switches as delivered, button released
	initial begin
		config_switch = 8'hff;
		service_select_button = 1'b0;
	end
	// Installer sets the switch block at a falling edge
	task set_sw(input [7:0] v);
		begin
			@(negedge clk_sys);
			config_switch = v;
		end
	endtask
	// Press held three cycles, then released three
	task press;
		begin
			@(negedge clk_sys);
			service_select_button = 1'b1;
			repeat (3) @(negedge clk_sys);
			service_select_button = 1'b0;
			repeat (3) @(negedge clk_sys);
		end
	endtask
endmodule

// file: testbench.sv
// Self-checking testbench for the load shed configuration and review block
`timescale 1ns/1ps
module testbench;
	localparam TO = 20;
	reg clk_sys = 0, rst_n = 0, generator_present = 0, shed_event = 0;
	reg [7:0] total_current = 8'h42, shed_current_drop = 8'h0;
	reg [2:0] shed_relay = 3'h0, shed_step = 3'h0;
	wire [7:0] config_switch, current_limit_amps, load_meter_value;
	wire service_select_button, energy_mgmt_enable, review_active;
	wire [2:0] shed_step_relay;
	wire [5:0] relay_is_low_voltage, load_indicator;
	integer errors = 0, n_tests = 0, i, k;
	// Rows: switch block, then relay order first shed first
	reg [31:0] rows [0:7];
	initial begin
		rows[0] = 32'hff654321;
		rows[1] = 32'h0e465321;
		rows[2] = 32'ha5436521;
		rows[3] = 32'h14432651;
		rows[4] = 32'h5b432165;
		rows[5] = 32'h02645321;
		rows[6] = 32'hf1463521;
		rows[7] = 32'h08436251;
	end
	always #50 clk_sys = ~clk_sys;
	panel_model pm (.clk_sys, .config_switch, .service_select_button);
	load_shed_config_display #(.REVIEW_TIMEOUT_CYCLES(TO)) uut (.clk_sys, .rst_n, .config_switch,
		.service_select_button, .generator_present, .total_current, .shed_event, .shed_relay, .shed_current_drop,
		.shed_step, .shed_step_relay, .energy_mgmt_enable, .current_limit_amps, .relay_is_low_voltage,
		.load_meter_value, .load_indicator, .review_active);
	// Compare and count
	task check(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Verdict and end of run
	task wrap_up;
		begin
			if (errors == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Reset, table of columns, then the review walk
	initial begin
		repeat (5) @(negedge clk_sys);
		check(current_limit_amps, 8'h2d);
		check(relay_is_low_voltage, 8'h30);
		check(review_active, 8'h0);
		rst_n = 1;
		for (i = 0; i < 8; i = i + 1) begin
			pm.set_sw(rows[i][31:24]);
			generator_present = i[0] | i[2];
			total_current = {5'h08, i[2:0]};
			for (k = 0; k < 6; k = k + 1) begin
				shed_step = k;
				repeat (5) @(negedge clk_sys);
				check(shed_step_relay, rows[i][22-4*k -: 3]);
			end
			check(current_limit_amps, rows[i][28] ? 8'h2d : 8'h3c);
			check(energy_mgmt_enable, generator_present & ~rows[i][27]);
			check(load_meter_value, total_current);
		end
		for (k = 1; k < 7; k = k + 1) begin
			shed_relay = k;
			shed_current_drop = 8'h10 + k;
			shed_event = 1;
			@(negedge clk_sys);
		end
		shed_event = 0;
		total_current = 8'h42;
		for (k = 0; k < 7; k = k + 1) begin
			pm.press;
			check(review_active, k < 6);
			check(load_indicator, k < 6 ? 8'h20 >> k : 8'h0);
			check(load_meter_value, k < 6 ? 8'h11 + k : 8'h42);
		end
		// Presses 15 cycles apart, check 14 later: only a restarted timer keeps review up
		pm.press;
		repeat (8) @(negedge clk_sys);
		pm.press;
		repeat (8) @(negedge clk_sys);
		check(load_indicator, 8'h10);
		check(review_active, 8'h1);
		check(load_meter_value, 8'h12);
		repeat (TO) @(negedge clk_sys);
		check(review_active, 8'h0);
		check(load_indicator, 8'h0);
		check(load_meter_value, 8'h42);
		wrap_up;
	end
	// Watchdog for a hung run
	initial begin
		#200000;
		errors = errors + 1;
		wrap_up;
	end
endmodule
